// [design/phy_mgmt_pkg.sv]
// Purpose: constants shared by the management register block of the phy
// Assumes: 16-bit management registers, 5-bit register and phy addresses
// Notes:   offsets, field positions and reset values are named once here
package phy_mgmt_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [4:0] REG_LOCAL_NP   = 5'h07;
	localparam logic [4:0] REG_PARTNER_NP = 5'h08;
	localparam logic [4:0] REG_RXERR_CNT  = 5'h15;
	localparam logic [4:0] REG_IRQ        = 5'h1B;
	localparam logic [4:0] REG_CTRL       = 5'h1F;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int NP_MORE      = 15;
	localparam int NP_ACK       = 14;
	localparam int NP_MSG       = 13;
	localparam int NP_COMPLY    = 12;
	localparam int NP_TOGGLE    = 11;
	localparam int IRQ_EN_LSB   = 8;
	localparam int CTRL_XOVER   = 13;
	localparam int CTRL_ENERGY  = 12;
	localparam int CTRL_FORCE   = 11;
	localparam int CTRL_PSAVE   = 10;
	localparam int CTRL_POL     = 9;
	localparam int CTRL_JABBER  = 8;
	localparam int CTRL_AN_DONE = 7;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic        NP_MORE_RST   = 1'h0;
	localparam logic        NP_MSG_RST    = 1'h1;
	localparam logic        NP_COMPLY_RST = 1'h0;
	localparam logic [10:0] NP_CODE_RST   = 11'h001;
	localparam logic [15:0] PARTNER_RST   = 16'h0000;
	localparam logic [15:0] RXERR_RST     = 16'h0000;
	localparam logic [7:0]  IRQ_EN_RST    = 8'h00;
	localparam logic [7:0]  IRQ_FLAG_RST  = 8'h00;
	localparam logic        FORCE_RST     = 1'h0;
	localparam logic        PSAVE_RST     = 1'h1;
	localparam logic        POL_RST       = 1'h0;
	localparam logic        JABBER_RST    = 1'h1;
	localparam logic        IRQ_PIN_RST   = 1'h1;

	// ----------------------------------------------------------------
	// management frame and receive error count limit
	// ----------------------------------------------------------------
	localparam logic [5:0]  PRE_LEN  = 6'h20;
	localparam logic [5:0]  HDR_LEN  = 6'h0C;
	localparam logic [5:0]  DATA_LEN = 6'h10;
	localparam logic [1:0]  OP_READ  = 2'h2;
	localparam logic [1:0]  OP_WRITE = 2'h1;
	localparam logic [15:0] CNT_MAX  = 16'hFFFF;

	typedef enum logic [2:0] {
		ST_PRE   = 3'b000,
		ST_START = 3'b001,
		ST_HDR   = 3'b010,
		ST_TA    = 3'b011,
		ST_DATA  = 3'b100
	} mdio_state_t;

endpackage

// [design/phy_mgmt_regs.sv]
// Purpose: management register subset of a 10/100 phy behind the serial
//          management pins: next pages, receive error count, interrupts, control
// Assumes: management clock and data arrive as pins and are sampled on i_sys_clk;
//          core status and events come from logic on i_sys_clk
// Notes:   one frame is decoded per preamble; reads go out after turnaround
module phy_mgmt_regs (
	input  wire logic        i_sys_clk,          // system clock, 200 MHz
	input  wire logic        i_rst_b,            // synchronous reset, active low
	input  wire logic        i_mdc,              // management clock pin
	input  wire logic        i_mdio,             // management data pin, input
	output logic             o_mdio,             // management data pin, output
	output logic             o_mdio_oe,          // management data drive enable
	input  wire logic [4:0]  i_strap_phy_addr,   // phy address strap pins
	input  wire logic        i_strap_xover_dis,  // pair swap disable strap pin
	input  wire logic        i_tx_toggle,        // toggle of last sent code word
	input  wire logic [15:0] i_partner_page,     // received partner next page
	input  wire logic        i_partner_valid,    // partner page received pulse
	input  wire logic        i_rx_dv,            // receive data valid
	input  wire logic        i_rx_er,            // receive error
	input  wire logic        i_energy_detect,    // signal on receive pair
	input  wire logic        i_an_complete,      // auto-negotiation done
	input  wire logic [7:0]  i_events,           // event pulses, jabber..link up
	output logic [15:0]      o_local_page,       // local next page to transmit
	output logic             o_xover_dis,        // pair swapping disabled
	output logic             o_force_link,       // force link pass
	output logic             o_power_save,       // power saving enabled
	output logic             o_jabber_en,        // jabber counter enabled
	output logic             o_irq               // interrupt pin, set polarity
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic       mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2;
	logic       xs_s1, xs_s2;
	logic [4:0] pa_s1, pa_s2, phy_addr;

	// mdc_s3 only serves the edge detect, so mdc_s1 feeds nothing but mdc_s2
	always_ff @(posedge i_sys_clk) begin
		mdc_s1  <= i_mdc;
		mdc_s2  <= mdc_s1;
		mdc_s3  <= mdc_s2;
		mdio_s1 <= i_mdio;
		mdio_s2 <= mdio_s1;
		xs_s1   <= i_strap_xover_dis;
		xs_s2   <= xs_s1;
		pa_s1   <= i_strap_phy_addr;
		pa_s2   <= pa_s1;
	end

	// strap is held while reset is low, so its level is caught by the clock
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			phy_addr <= pa_s2;
		end
	end

	logic mdc_rise;
	assign mdc_rise = mdc_s2 & ~mdc_s3;

	// ----------------------------------------------------------------
	// management frame engine
	// ----------------------------------------------------------------
	phy_mgmt_pkg::mdio_state_t state, next_state;
	logic [5:0]  cnt, next_cnt;
	logic [15:0] shift, next_shift;
	logic [4:0]  reg_addr, next_reg_addr;
	logic        is_read, next_is_read;
	logic        next_mdio, next_mdio_oe;
	logic        rd_pulse, wr_pulse;
	logic [11:0] hdr;
	logic [15:0] wr_data, rd_data;

	assign hdr     = {shift[10:0], mdio_s2};
	assign wr_data = {shift[14:0], mdio_s2};

	// every step happens on a sampled rising edge of the management clock
	always_comb begin
		next_state    = state;
		next_cnt      = cnt;
		next_shift    = shift;
		next_reg_addr = reg_addr;
		next_is_read  = is_read;
		next_mdio     = o_mdio;
		next_mdio_oe  = o_mdio_oe;
		rd_pulse      = 1'b0;
		wr_pulse      = 1'b0;
		if (mdc_rise) begin
			unique case (state)
				phy_mgmt_pkg::ST_PRE: begin
					if (mdio_s2) begin
						if (cnt != phy_mgmt_pkg::PRE_LEN) begin
							next_cnt = cnt + 6'h01;
						end
					end else begin
						if (cnt == phy_mgmt_pkg::PRE_LEN) begin
							next_state = phy_mgmt_pkg::ST_START;
						end
						next_cnt = 6'h00;
					end
				end
				phy_mgmt_pkg::ST_START: begin
					next_state = mdio_s2 ? phy_mgmt_pkg::ST_HDR : phy_mgmt_pkg::ST_PRE;
				end
				phy_mgmt_pkg::ST_HDR: begin
					next_shift = wr_data;
					next_cnt   = cnt + 6'h01;
					if (cnt == phy_mgmt_pkg::HDR_LEN - 6'h01) begin
						next_cnt      = 6'h00;
						next_reg_addr = hdr[4:0];
						next_is_read  = (hdr[11:10] == phy_mgmt_pkg::OP_READ);
						// a frame for another address is ignored and waits for a new preamble
						if (hdr[9:5] == phy_addr && (hdr[11:10] == phy_mgmt_pkg::OP_READ
						    || hdr[11:10] == phy_mgmt_pkg::OP_WRITE)) begin
							next_state = phy_mgmt_pkg::ST_TA;
						end else begin
							next_state = phy_mgmt_pkg::ST_PRE;
						end
					end
				end
				phy_mgmt_pkg::ST_TA: begin
					if (cnt == 6'h00) begin
						next_cnt = 6'h01;
						if (is_read) begin
							rd_pulse     = 1'b1;
							next_shift   = rd_data;
							next_mdio_oe = 1'b1;
							next_mdio    = 1'b0;
						end
					end else begin
						next_cnt   = 6'h00;
						next_state = phy_mgmt_pkg::ST_DATA;
						if (is_read) begin
							next_mdio  = shift[15];
							next_shift = {shift[14:0], 1'b0};
						end
					end
				end
				phy_mgmt_pkg::ST_DATA: begin
					next_cnt = cnt + 6'h01;
					if (is_read) begin
						next_mdio  = shift[15];
						next_shift = {shift[14:0], 1'b0};
					end else begin
						next_shift = wr_data;
					end
					if (cnt == phy_mgmt_pkg::DATA_LEN - 6'h01) begin
						next_cnt     = 6'h00;
						next_state   = phy_mgmt_pkg::ST_PRE;
						next_mdio_oe = 1'b0;
						next_mdio    = 1'b0;
						wr_pulse     = ~is_read;
					end
				end
				default: begin
					next_state = phy_mgmt_pkg::ST_PRE;
					next_cnt   = 6'h00;
				end
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			state     <= phy_mgmt_pkg::ST_PRE;
			cnt       <= 6'h00;
			shift     <= 16'h0000;
			reg_addr  <= 5'h00;
			is_read   <= 1'b0;
			o_mdio    <= 1'b0;
			o_mdio_oe <= 1'b0;
		end else begin
			state     <= next_state;
			cnt       <= next_cnt;
			shift     <= next_shift;
			reg_addr  <= next_reg_addr;
			is_read   <= next_is_read;
			o_mdio    <= next_mdio;
			o_mdio_oe <= next_mdio_oe;
		end
	end

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	logic        np_more, np_msg, np_comply, next_np_more, next_np_msg, next_np_comply;
	logic [10:0] np_code, next_np_code;
	logic [15:0] partner, next_partner, rxerr_cnt, next_rxerr_cnt;
	logic [7:0]  irq_en, next_irq_en, flags, next_flags;
	logic        force_link, psave, pol, jab_en, xover_dis;
	logic        next_force, next_psave, next_pol, next_jab, next_xover;
	logic        rx_er_q, rd_irq, irq_any, next_irq;

	assign rd_irq  = rd_pulse && reg_addr == phy_mgmt_pkg::REG_IRQ;
	assign irq_any = |(flags & irq_en);

	// read view; unlisted offsets and reserved bits read as zero
	always_comb begin
		rd_data = 16'h0000;
		unique case (reg_addr)
			phy_mgmt_pkg::REG_LOCAL_NP:
				rd_data = {np_more, 1'b0, np_msg, np_comply, i_tx_toggle, np_code};
			phy_mgmt_pkg::REG_PARTNER_NP: rd_data = partner;
			phy_mgmt_pkg::REG_RXERR_CNT:  rd_data = rxerr_cnt;
			phy_mgmt_pkg::REG_IRQ:        rd_data = {irq_en, flags};
			phy_mgmt_pkg::REG_CTRL:
				rd_data = {2'h0, xover_dis, i_energy_detect, force_link, psave, pol,
				           jab_en, i_an_complete, 7'h00};
			default: rd_data = 16'h0000;
		endcase
	end

	// next register values; status bits ignore writes
	always_comb begin
		next_np_more   = np_more;
		next_np_msg    = np_msg;
		next_np_comply = np_comply;
		next_np_code   = np_code;
		next_irq_en    = irq_en;
		next_force     = force_link;
		next_psave     = psave;
		next_pol       = pol;
		next_jab       = jab_en;
		next_xover     = xover_dis;
		next_partner   = partner;
		next_rxerr_cnt = rxerr_cnt;
		if (i_partner_valid) begin
			// toggle is stored against what was sent, not as received
			next_partner = {i_partner_page[15:12], ~i_tx_toggle, i_partner_page[10:0]};
		end
		// one count per error burst inside a frame; saturates rather than wraps
		if (i_rx_dv && i_rx_er && !rx_er_q && rxerr_cnt != phy_mgmt_pkg::CNT_MAX) begin
			next_rxerr_cnt = rxerr_cnt + 16'h0001;
		end
		// an event in the clearing read's cycle survives: set wins
		next_flags = (flags & ~{8{rd_irq}}) | i_events;
		if (wr_pulse) begin
			unique case (reg_addr)
				phy_mgmt_pkg::REG_LOCAL_NP: begin
					next_np_more   = wr_data[phy_mgmt_pkg::NP_MORE];
					next_np_msg    = wr_data[phy_mgmt_pkg::NP_MSG];
					next_np_comply = wr_data[phy_mgmt_pkg::NP_COMPLY];
					next_np_code   = wr_data[10:0];
				end
				phy_mgmt_pkg::REG_IRQ: next_irq_en = wr_data[15:phy_mgmt_pkg::IRQ_EN_LSB];
				phy_mgmt_pkg::REG_CTRL: begin
					next_xover = wr_data[phy_mgmt_pkg::CTRL_XOVER];
					next_force = wr_data[phy_mgmt_pkg::CTRL_FORCE];
					next_psave = wr_data[phy_mgmt_pkg::CTRL_PSAVE];
					next_pol   = wr_data[phy_mgmt_pkg::CTRL_POL];
					next_jab   = wr_data[phy_mgmt_pkg::CTRL_JABBER];
				end
				default: next_np_more = np_more;
			endcase
		end
		next_irq = irq_any ~^ pol;
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			np_more    <= phy_mgmt_pkg::NP_MORE_RST;
			np_msg     <= phy_mgmt_pkg::NP_MSG_RST;
			np_comply  <= phy_mgmt_pkg::NP_COMPLY_RST;
			np_code    <= phy_mgmt_pkg::NP_CODE_RST;
			partner    <= phy_mgmt_pkg::PARTNER_RST;
			rxerr_cnt  <= phy_mgmt_pkg::RXERR_RST;
			irq_en     <= phy_mgmt_pkg::IRQ_EN_RST;
			flags      <= phy_mgmt_pkg::IRQ_FLAG_RST;
			force_link <= phy_mgmt_pkg::FORCE_RST;
			psave      <= phy_mgmt_pkg::PSAVE_RST;
			pol        <= phy_mgmt_pkg::POL_RST;
			jab_en     <= phy_mgmt_pkg::JABBER_RST;
			xover_dis  <= xs_s2;
			rx_er_q    <= 1'b0;
			o_irq      <= phy_mgmt_pkg::IRQ_PIN_RST;
		end else begin
			np_more    <= next_np_more;
			np_msg     <= next_np_msg;
			np_comply  <= next_np_comply;
			np_code    <= next_np_code;
			partner    <= next_partner;
			rxerr_cnt  <= next_rxerr_cnt;
			irq_en     <= next_irq_en;
			flags      <= next_flags;
			force_link <= next_force;
			psave      <= next_psave;
			pol        <= next_pol;
			jab_en     <= next_jab;
			xover_dis  <= next_xover;
			rx_er_q    <= i_rx_er & i_rx_dv;
			o_irq      <= next_irq;
		end
	end

	assign o_local_page = {np_more, 1'b0, np_msg, np_comply, i_tx_toggle, np_code};
	assign o_xover_dis  = xover_dis;
	assign o_force_link = force_link;
	assign o_power_save = psave;
	assign o_jabber_en  = jab_en;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);

	property p_flag_set;
		i_events != 8'h00 |=> (flags & $past(i_events)) == $past(i_events);
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("event flag not set");

	property p_flag_no_write;
		wr_pulse && reg_addr == phy_mgmt_pkg::REG_IRQ && !rd_irq
		|=> flags == ($past(flags) | $past(i_events));
	endproperty
	a_flag_no_write: assert property (p_flag_no_write) else $error("flags written");

	property p_read_clear;
		rd_irq && i_events == 8'h00 |=> flags == 8'h00 ##1 shift[7:0] == $past(flags, 2);
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("read did not clear");

	property p_irq_pin;
		##1 o_irq == ($past(irq_any) ~^ $past(pol));
	endproperty
	a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin wrong");

	property p_irq_idle_low_act;
		(!pol && !irq_any) [*2] |-> o_irq;
	endproperty
	a_irq_idle_low_act: assert property (p_irq_idle_low_act) else $error("pin active");

	property p_err_count;
		i_rx_dv && i_rx_er && !rx_er_q && rxerr_cnt != phy_mgmt_pkg::CNT_MAX
		|=> rxerr_cnt == $past(rxerr_cnt) + 16'h0001;
	endproperty
	a_err_count: assert property (p_err_count) else $error("error count missed");

	property p_partner_toggle;
		i_partner_valid |=> partner[phy_mgmt_pkg::NP_TOGGLE] == !$past(i_tx_toggle);
	endproperty
	a_partner_toggle: assert property (p_partner_toggle) else $error("toggle");

	property p_partner_comply;
		i_partner_valid |=> partner[phy_mgmt_pkg::NP_COMPLY] == $past(i_partner_page[12]);
	endproperty
	a_partner_comply: assert property (p_partner_comply) else $error("comply bit");

	property p_local_write;
		wr_pulse && reg_addr == phy_mgmt_pkg::REG_LOCAL_NP
		|=> np_code == $past(wr_data[10:0]) && np_more == $past(wr_data[15]);
	endproperty
	a_local_write: assert property (p_local_write) else $error("local page write");

	property p_ctrl_write;
		wr_pulse && reg_addr == phy_mgmt_pkg::REG_CTRL
		|=> o_force_link == $past(wr_data[11]) && o_xover_dis == $past(wr_data[13]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write");

	property p_toggle_read;
		rd_pulse && reg_addr == phy_mgmt_pkg::REG_LOCAL_NP |=> shift[11] == $past(i_tx_toggle);
	endproperty
	a_toggle_read: assert property (p_toggle_read) else $error("toggle read");

	c_read: cover property (rd_pulse ##[1:400] state == phy_mgmt_pkg::ST_PRE);
	c_write: cover property (wr_pulse && reg_addr == phy_mgmt_pkg::REG_CTRL);
	c_irq: cover property (irq_any && pol);

endmodule

// [verif/mgmt_station.sv]
// Purpose: station management controller that frames reads and writes on mdc/mdio
// Assumes: the shared data line has a pull-up; the bench resolves it into i_line
// Notes:   mdc stands low between frames; each half period is HALF system cycles
module mgmt_station (
	input  wire logic i_sys_clk, // system clock, steps the management clock
	input  wire logic i_line,    // resolved management data line
	output logic      o_mdc,     // management clock, still outside frames
	output logic      o_mdio,    // data driven by the station
	output logic      o_mdio_en  // high while the station drives the line
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// bit and frame sequencing
	// ----------------------------------------------------------------
	// two cycles per half is the floor; four leaves room for the synchroniser
	localparam int HALF = 4;

	initial begin
		o_mdc = 1'b0;
		o_mdio = 1'b1;
		o_mdio_en = 1'b0;
	end

	// data changes just after mdc falls and is sampled just before it rises
	task automatic clk_bit(input logic b, input logic drv, output logic seen);
		@(negedge i_sys_clk);
		o_mdio_en = drv;
		o_mdio = b;
		repeat (HALF - 1) @(negedge i_sys_clk);
		seen = i_line;
		o_mdc = 1'b1;
		repeat (HALF) @(negedge i_sys_clk);
		o_mdc = 1'b0;
	endtask

	// one full frame; on a read the line is released from turnaround onward
	task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
			input logic [15:0] wd, output logic [15:0] rd, output logic ta);
		logic [63:0] bits;
		logic        s;
		int          i;
		bits = {32'hFFFFFFFF, 2'h1, op, phy, rg, 2'h2, wd};
		rd = 16'h0000;
		ta = 1'b1;
		for (i = 63; i >= 0; i--) begin
			clk_bit(bits[i], !(op == phy_mgmt_pkg::OP_READ && i <= 17), s);
			if (i == 16) ta = s;
			if (i < 16) rd[i] = s;
		end
		@(negedge i_sys_clk);
		o_mdio_en = 1'b0;
		o_mdio = 1'b1;
		repeat (4 * HALF) @(negedge i_sys_clk);
	endtask
endmodule

// [verif/test_phy_mgmt_regs.sv]
// Purpose: self-checking bench for the management register block
// Assumes: a queue-free integer model of the registers predicts every read
// Notes:   inputs change on the falling edge; random data from an lfsr
`define CHK(nm, ex, got) \
	begin \
		compares++; \
		if ((got) !== 16'(ex)) begin \
			failures++; \
			$display("CHECK FAILED %s expected %h seen %h", nm, 16'(ex), got); \
		end \
	end
module test_phy_mgmt_regs;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// signals and model state
	// ----------------------------------------------------------------
	logic        clk = 1'b0, rst_b, mdc, st_bit, st_en, line, oe, mo, xs, tog, pv;
	logic        dv, er, en_det, an, irq, xd, fl, ps, jb;
	logic [4:0]  addr;
	logic [7:0]  ev;
	logic [15:0] pp, lp, r16;
	logic [15:0] seed = 16'h1D13;
	int          loc, partner, cnt, en, flags, ctrl, failures = 0, compares = 0;
	logic [4:0]  regs [6] = '{phy_mgmt_pkg::REG_LOCAL_NP, phy_mgmt_pkg::REG_PARTNER_NP,
		phy_mgmt_pkg::REG_RXERR_CNT, phy_mgmt_pkg::REG_IRQ, phy_mgmt_pkg::REG_CTRL, 5'h00};

	always #2.5 clk = ~clk;

	// pull-up on the shared line when nobody drives it
	assign line = oe ? mo : (st_en ? st_bit : 1'b1);

	phy_mgmt_regs phy_mgmt_regs_inst (.i_sys_clk(clk), .i_rst_b(rst_b), .i_mdc(mdc),
		.i_mdio(line), .o_mdio(mo), .o_mdio_oe(oe), .i_strap_phy_addr(addr),
		.i_strap_xover_dis(xs), .i_tx_toggle(tog), .i_partner_page(pp),
		.i_partner_valid(pv), .i_rx_dv(dv), .i_rx_er(er), .i_energy_detect(en_det),
		.i_an_complete(an), .i_events(ev), .o_local_page(lp), .o_xover_dis(xd),
		.o_force_link(fl), .o_power_save(ps), .o_jabber_en(jb), .o_irq(irq));

	mgmt_station mgmt_station_inst (.i_sys_clk(clk), .i_line(line), .o_mdc(mdc),
		.o_mdio(st_bit), .o_mdio_en(st_en));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed;
	endfunction

	// expected read value; reserved bits and unmapped offsets read zero
	function automatic logic [15:0] exp_reg(input logic [4:0] r);
		case (r)
			phy_mgmt_pkg::REG_LOCAL_NP:   return 16'(loc | (int'(tog) << 11));
			phy_mgmt_pkg::REG_PARTNER_NP: return 16'(partner);
			phy_mgmt_pkg::REG_RXERR_CNT:  return 16'(cnt);
			phy_mgmt_pkg::REG_IRQ:        return {8'(en), 8'(flags)};
			phy_mgmt_pkg::REG_CTRL:       return 16'(ctrl | (int'(en_det) << 12) | (int'(an) << 7));
			default:                      return 16'h0000;
		endcase
	endfunction

	task automatic rd_chk(input logic [4:0] r);
		logic [15:0] v, e;
		logic        ta;
		e = exp_reg(r);
		mgmt_station_inst.frame(phy_mgmt_pkg::OP_READ, addr, r, 16'h0000, v, ta);
		`CHK("turnaround", 0, ta)
		`CHK($sformatf("reg %h", r), e, v)
		if (r == phy_mgmt_pkg::REG_IRQ) flags = 0;
	endtask

	// the model follows only frames aimed at our strapped address
	task automatic wr(input logic [4:0] r, input logic [15:0] d, input logic [4:0] ph);
		logic [15:0] v;
		logic        ta;
		mgmt_station_inst.frame(phy_mgmt_pkg::OP_WRITE, ph, r, d, v, ta);
		if (ph == addr) begin
			case (r)
				phy_mgmt_pkg::REG_LOCAL_NP: loc = d & 16'hB7FF;
				phy_mgmt_pkg::REG_IRQ:      en = d[15:8];
				phy_mgmt_pkg::REG_CTRL:     ctrl = d & 16'h2F00;
				default: ;
			endcase
		end
	endtask

	task automatic chk_outs();
		`CHK("local_page", loc | (int'(tog) << 11), lp)
		`CHK("xover_dis", ctrl[13], xd)
		`CHK("force_link", ctrl[11], fl)
		`CHK("power_save", ctrl[10], ps)
		`CHK("jabber_en", ctrl[8], jb)
		`CHK("irq_pin", ((flags & en) != 0) == ctrl[9], irq)
	endtask

	task automatic pulse(input logic [7:0] e);
		ev = e;
		@(negedge clk);
		ev = 8'h00;
		flags |= e;
		repeat (3) @(negedge clk);
	endtask

	task automatic wrap_up();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		repeat (80000) @(posedge clk);
		failures++;
		wrap_up();
	end

	initial begin
		int k;
		logic ta_bit;
		rst_b = 1'b0;
		r16 = rnd();
		addr = r16[4:0];
		{xs, tog, pv, dv, er, en_det, an, ev, pp} = {7'h40, 8'h00, 16'h0000};
		{loc, partner, cnt, en, flags, ctrl} = {32'h2001, 128'h0, 32'h2500};
		repeat (6) @(negedge clk);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		chk_outs();
		foreach (regs[j]) rd_chk(regs[j]);
		$display("test reset values done");
		for (k = 0; k < 2; k++) begin
			r16 = rnd();
			en_det = r16[0];
			an = r16[1];
			foreach (regs[j]) wr(regs[j], rnd(), addr);
			foreach (regs[j]) rd_chk(regs[j]);
			chk_outs();
		end
		wr(phy_mgmt_pkg::REG_LOCAL_NP, 16'h8FFF, addr ^ 5'h01);
		rd_chk(phy_mgmt_pkg::REG_LOCAL_NP);
		// reserved op codes are refused, so the page must not move
		mgmt_station_inst.frame(2'h3, addr, phy_mgmt_pkg::REG_LOCAL_NP, 16'h8FFF,
			r16, ta_bit);
		mgmt_station_inst.frame(2'h0, addr, phy_mgmt_pkg::REG_LOCAL_NP, 16'h8FFF,
			r16, ta_bit);
		rd_chk(phy_mgmt_pkg::REG_LOCAL_NP);
		$display("test write and read back done");
		for (k = 1; k >= 0; k--) begin
			tog = k[0];
			r16 = rnd();
			pp = r16;
			pv = 1'b1;
			@(negedge clk);
			pv = 1'b0;
			partner = {r16[15:12], ~k[0], r16[10:0]};
			repeat (2) @(negedge clk);
			rd_chk(phy_mgmt_pkg::REG_PARTNER_NP);
			rd_chk(phy_mgmt_pkg::REG_LOCAL_NP);
		end
		$display("test pages and toggle done");
		// a held error counts once; an error outside valid data never counts
		for (k = 0; k < 3; k++) begin
			dv = 1'b1;
			er = 1'b1;
			repeat (k + 1) @(negedge clk);
			er = 1'b0;
			@(negedge clk);
			dv = 1'b0;
			cnt++;
			er = 1'b1;
			@(negedge clk);
			er = 1'b0;
			@(negedge clk);
		end
		rd_chk(phy_mgmt_pkg::REG_RXERR_CNT);
		$display("test receive errors done");
		for (k = 0; k < 8; k++) begin
			wr(phy_mgmt_pkg::REG_CTRL, 16'(ctrl ^ 16'h0200), addr);
			wr(phy_mgmt_pkg::REG_IRQ, 16'(1 << (k + 8)), addr);
			pulse(8'(~(1 << k)));
			chk_outs();
			pulse(8'(1 << k));
			chk_outs();
			rd_chk(phy_mgmt_pkg::REG_IRQ);
			chk_outs();
			rd_chk(phy_mgmt_pkg::REG_IRQ);
		end
		$display("test interrupts done");
		// a second reset must catch the swap strap at its other level
		xs = 1'b0;
		rst_b = 1'b0;
		repeat (6) @(negedge clk);
		rst_b = 1'b1;
		{loc, partner, cnt, en, flags, ctrl} = {32'h2001, 128'h0, 32'h0500};
		repeat (4) @(negedge clk);
		chk_outs();
		foreach (regs[j]) rd_chk(regs[j]);
		$display("test second reset done");
		wrap_up();
	end
endmodule
